// file: include/nand_seq_map.svh
// constants for the nand program, erase and move controller
// Overview of operation
// - controller sends 80h, column and row cycles, data bytes, then 15h
// - with ready set and array busy, controller checks prior cache error flag
// - to finish a cache series, poll array ready then read both error flags
// - on multi-die targets use status-enhanced 78h, never plain 70h
// - erase is 60h, three row cycles, then D0h
// - after erase or program, controller reads op error flag when fully ready
// - no interleaved multi-die work between move-read and move-program
// - controller may read and check moved data before move-program; this one has no data read, it can only change columns with 85h
// - pages within a block are programmed in ascending order 0 to 63; the code takes any page first after reset or page 63, then only the next page
`ifndef NAND_SEQ_MAP_SVH
`define NAND_SEQ_MAP_SVH
`define CMD_PROG_SETUP   8'h80
`define CMD_PROG_CONFIRM 8'h10
`define CMD_CACHE_CONFIRM 8'h15
`define CMD_COL_CHANGE   8'h85
`define CMD_ERASE_SETUP  8'h60
`define CMD_ERASE_CONFIRM 8'hd0
`define CMD_READ_SETUP   8'h00
`define CMD_MOVE_CONFIRM 8'h35
`define CMD_STATUS_ENH   8'h78
`define CMD_RESET        8'hff
`define ST_FAIL_BIT      0
`define ST_PRIOR_CACHE_ERROR_FLAG_BIT     1
`define ST_ARRAY_READY_FLAG_BIT      5
`define ST_RDY_BIT       6
`define REG_CTRL         4'h0
`define REG_ADDR_LO      4'h1
`define REG_ADDR_HI      4'h2
`define REG_DATA         4'h3
`define REG_STATUS       4'h4
`define REG_RESULT       4'h5
`define REG_DIE          4'h6
`define OP_CACHE_PROG    3'h1
`define OP_PAGE_PROG     3'h2
`define OP_ERASE         3'h3
`define OP_MOVE_READ     3'h4
`define OP_MOVE_PROG     3'h5
`define OP_COL_CHANGE    3'h6
`define OP_RESET         3'h7
`define WE_PULSE_NS      40
`define WE_PULSE_CYC     ((`WE_PULSE_NS + 19) / 20)
`define LAST_PAGE        6'h3f
`endif

// file: include/nand_seq_pkg.sv
// types for the nand program, erase and move controller
package nand_seq_pkg;
    typedef enum logic [3:0] {
        S_IDLE, S_CMD, S_ADDR, S_DATA, S_CONF, S_WAIT_RB, S_STAT_CMD, S_STAT_ADDR,
        S_STAT_RD, S_STAT_CHK
    } seq_state_t;
    typedef struct packed {
        logic [7:0] dq;
        logic       cle;
        logic       ale;
        logic       we_n;
        logic       re_n;
        logic       dq_oe;
    } bus_out_t;
    typedef struct packed {
        logic       op_error;
        logic       prior_cache_error;
        logic       array_ready;
        logic       ready;
        logic       move_open;
        logic       order_error;
    } result_t;
endpackage

// file: verilog/nand_seq_ctrl.sv
// host controller sequencing nand cached program, erase and internal move
//
// Added by the designer: the plain strobed port and the placing of the registers.
`timescale 1ns/1ps
`include "nand_seq_map.svh"
module nand_seq_ctrl #(
    parameter int ADDR_CYCLES = 5,
    parameter int ROW_CYCLES  = 3
) (
    input  wire logic        ref_clk,
    input  wire logic        srst,
    input  wire logic [3:0]  reg_addr,
    input  wire logic [31:0] reg_wdata,
    input  wire logic        reg_wr,
    input  wire logic        reg_rd,
    output logic      [31:0] reg_rdata,
    output logic             data_ready,
    output logic      [7:0]  dq_out,
    output logic             dq_oe,
    input  wire logic [7:0]  dq_in,
    output logic             cle,
    output logic             ale,
    output logic             ce_n,
    output logic             we_n,
    output logic             re_n,
    input  wire logic        ready_busy_n
);
    nand_seq_pkg::seq_state_t st_q, st_d;
    nand_seq_pkg::bus_out_t   bo_q, bo_d;
    nand_seq_pkg::result_t    rs_q, rs_d;
    logic [2:0]  op_q, op_d;
    logic [39:0] addr_q, addr_d;
    logic [7:0]  data_q, data_d;
    logic        data_full_q, data_full_d;
    logic        data_last_q, data_last_d;
    logic        busy_q, busy_d;
    logic [2:0]  cnt_q, cnt_d;
    logic [2:0]  ph_q, ph_d;
    logic [2:0]  die_q, die_d;
    logic [7:0]  stat_q, stat_d;
    logic [5:0]  next_page_q, next_page_d;
    logic        first_q, first_d;
    logic [31:0] rdata_d;

    function automatic logic [7:0] addr_byte(input logic [39:0] a, input logic [2:0] i);
        // shifting past the top yields zero instead of an unknown byte on the bus
        addr_byte = 8'(a >> {i, 3'h0});
    endfunction

    // which command opens and closes each operation
    function automatic logic [7:0] setup_cmd(input logic [2:0] op);
        case (op)
            `OP_ERASE:     setup_cmd = `CMD_ERASE_SETUP;
            `OP_MOVE_READ: setup_cmd = `CMD_READ_SETUP;
            `OP_MOVE_PROG,
            `OP_COL_CHANGE: setup_cmd = `CMD_COL_CHANGE;
            `OP_RESET:     setup_cmd = `CMD_RESET;
            default:       setup_cmd = `CMD_PROG_SETUP;
        endcase
    endfunction

    function automatic logic [7:0] confirm_cmd(input logic [2:0] op);
        case (op)
            `OP_CACHE_PROG: confirm_cmd = `CMD_CACHE_CONFIRM;
            `OP_ERASE:      confirm_cmd = `CMD_ERASE_CONFIRM;
            `OP_MOVE_READ:  confirm_cmd = `CMD_MOVE_CONFIRM;
            default:        confirm_cmd = `CMD_PROG_CONFIRM;
        endcase
    endfunction

    // one bus cycle: drive, strobe low for a phase, then high
    always_comb
    begin
        st_d = st_q;
        bo_d = bo_q;
        rs_d = rs_q;
        op_d = op_q;
        addr_d = addr_q;
        data_d = data_q;
        data_full_d = data_full_q;
        data_last_d = data_last_q;
        busy_d = busy_q;
        cnt_d = cnt_q;
        ph_d = ph_q;
        die_d = die_q;
        stat_d = stat_q;
        next_page_d = next_page_q;
        first_d = first_q;
        if (reg_wr && reg_addr == `REG_ADDR_LO)
            addr_d[31:0] = reg_wdata;
        if (reg_wr && reg_addr == `REG_ADDR_HI)
            addr_d[39:32] = reg_wdata[7:0];
        if (reg_wr && reg_addr == `REG_DIE)
            die_d = reg_wdata[2:0];
        if (reg_wr && reg_addr == `REG_DATA && !data_full_q)
        begin
            data_d = reg_wdata[7:0];
            data_last_d = reg_wdata[8];
            data_full_d = 1'b1;
        end
        if (reg_wr && reg_addr == `REG_RESULT)
            rs_d.order_error = 1'b0;
        case (st_q)
            nand_seq_pkg::S_IDLE:
            begin
                bo_d.we_n = 1'b1;
                bo_d.re_n = 1'b1;
                bo_d.cle = 1'b0;
                bo_d.ale = 1'b0;
                bo_d.dq_oe = 1'b0;
                if (reg_wr && reg_addr == `REG_CTRL && reg_wdata[2:0] != 3'h0)
                begin
                    op_d = reg_wdata[2:0];
                    // once a move-read is open only column changes,
                    // status, reset and the move-program may follow
                    if (rs_q.move_open && !(reg_wdata[2:0] == `OP_MOVE_PROG
                        || reg_wdata[2:0] == `OP_COL_CHANGE || reg_wdata[2:0] == `OP_RESET))
                        rs_d.order_error = 1'b1;
                    // erase and move-read only when fully ready; the other
                    // commands also while only the array is busy
                    else if ((reg_wdata[2:0] == `OP_ERASE || reg_wdata[2:0] == `OP_MOVE_READ)
                        && !(rs_q.ready && rs_q.array_ready))
                        rs_d.order_error = 1'b1;
                    else if (!rs_q.ready && reg_wdata[2:0] != `OP_RESET)
                        rs_d.order_error = 1'b1;
                    else if ((reg_wdata[2:0] == `OP_CACHE_PROG
                        || reg_wdata[2:0] == `OP_PAGE_PROG)
                        && !first_q && addr_q[21:16] != next_page_q)
                        rs_d.order_error = 1'b1;
                    else
                    begin
                        st_d = nand_seq_pkg::S_CMD;
                        bo_d.dq = setup_cmd(reg_wdata[2:0]);
                        cnt_d = 3'h0;
                        ph_d = 3'h0;
                        busy_d = 1'b1;
                        if (reg_wdata[2:0] == `OP_MOVE_READ)
                            rs_d.move_open = 1'b1;
                        if (reg_wdata[2:0] == `OP_MOVE_PROG || reg_wdata[2:0] == `OP_RESET)
                            rs_d.move_open = 1'b0;
                        if (reg_wdata[2:0] == `OP_CACHE_PROG
                            || reg_wdata[2:0] == `OP_PAGE_PROG)
                        begin
                            first_d = addr_q[21:16] == `LAST_PAGE;
                            next_page_d = addr_q[21:16] + 6'h1;
                        end
                    end
                end
                else if (reg_wr && reg_addr == `REG_CTRL && reg_wdata[3])
                begin
                    // status poll through 78h with die select
                    st_d = nand_seq_pkg::S_STAT_CMD;
                    bo_d.dq = `CMD_STATUS_ENH;
                    ph_d = 3'h0;
                    busy_d = 1'b1;
                end
            end
            nand_seq_pkg::S_CMD, nand_seq_pkg::S_CONF, nand_seq_pkg::S_STAT_CMD:
            begin
                bo_d.cle = 1'b1;
                bo_d.ale = 1'b0;
                bo_d.dq_oe = 1'b1;
                ph_d = 3'(ph_q + 3'h1);
                bo_d.we_n = ph_q >= 3'(`WE_PULSE_CYC);
                if (ph_q == 3'(2 * `WE_PULSE_CYC))
                begin
                    ph_d = 3'h0;
                    cnt_d = 3'h0;
                    bo_d.cle = 1'b0;
                    if (st_q == nand_seq_pkg::S_STAT_CMD)
                    begin
                        st_d = nand_seq_pkg::S_STAT_ADDR;
                        bo_d.dq = {5'h0, die_q};
                    end
                    else if (st_q == nand_seq_pkg::S_CONF || op_q == `OP_RESET)
                    begin
                        st_d = nand_seq_pkg::S_WAIT_RB;
                        bo_d.dq_oe = 1'b0;
                    end
                    else
                    begin
                        st_d = nand_seq_pkg::S_ADDR;
                        bo_d.dq = op_q == `OP_ERASE ? addr_byte(addr_q, 3'h2)
                                                    : addr_byte(addr_q, 3'h0);
                        cnt_d = op_q == `OP_ERASE ? 3'h2 : 3'h0;
                    end
                end
            end
            nand_seq_pkg::S_ADDR, nand_seq_pkg::S_STAT_ADDR:
            begin
                bo_d.ale = 1'b1;
                ph_d = 3'(ph_q + 3'h1);
                bo_d.we_n = ph_q >= 3'(`WE_PULSE_CYC);
                if (ph_q == 3'(2 * `WE_PULSE_CYC))
                begin
                    ph_d = 3'h0;
                    cnt_d = 3'(cnt_q + 3'h1);
                    bo_d.dq = addr_byte(addr_q, 3'(cnt_q + 3'h1));
                    if (st_q == nand_seq_pkg::S_STAT_ADDR)
                    begin
                        st_d = nand_seq_pkg::S_STAT_RD;
                        bo_d.ale = 1'b0;
                        bo_d.dq_oe = 1'b0;
                    end
                    else if (cnt_q == 3'(ADDR_CYCLES - 1)
                        || (op_q == `OP_COL_CHANGE && cnt_q == 3'h1))
                    begin
                        bo_d.ale = 1'b0;
                        if (op_q == `OP_ERASE || op_q == `OP_MOVE_READ)
                        begin
                            st_d = nand_seq_pkg::S_CONF;
                            bo_d.dq = confirm_cmd(op_q);
                        end
                        else
                            st_d = nand_seq_pkg::S_DATA;
                    end
                end
            end
            nand_seq_pkg::S_DATA:
            begin
                // data waits on software; the strobe stalls rather than drop a byte
                if (ph_q == 3'h0 && data_full_q)
                begin
                    bo_d.dq = data_q;
                    ph_d = 3'h1;
                    bo_d.we_n = 1'b0;
                end
                else if (ph_q != 3'h0)
                begin
                    ph_d = 3'(ph_q + 3'h1);
                    bo_d.we_n = ph_q >= 3'(`WE_PULSE_CYC);
                    if (ph_q == 3'(2 * `WE_PULSE_CYC))
                    begin
                        ph_d = 3'h0;
                        data_full_d = 1'b0;
                        if (data_last_q)
                        begin
                            if (op_q == `OP_COL_CHANGE)
                                st_d = nand_seq_pkg::S_IDLE;
                            else
                            begin
                                st_d = nand_seq_pkg::S_CONF;
                                bo_d.dq = confirm_cmd(op_q);
                            end
                            busy_d = op_q != `OP_COL_CHANGE;
                        end
                    end
                end
            end
            nand_seq_pkg::S_WAIT_RB:
            begin
                // die busy for its own time; watch the pin
                ph_d = 3'(ph_q + 3'h1);
                if (ph_q == 3'h7 && ready_busy_n)
                begin
                    st_d = nand_seq_pkg::S_STAT_CMD;
                    bo_d.dq = `CMD_STATUS_ENH;
                    ph_d = 3'h0;
                end
            end
            nand_seq_pkg::S_STAT_RD:
            begin
                ph_d = 3'(ph_q + 3'h1);
                bo_d.re_n = ph_q >= 3'(`WE_PULSE_CYC);
                if (ph_q == 3'(`WE_PULSE_CYC))
                    stat_d = dq_in;
                if (ph_q == 3'(2 * `WE_PULSE_CYC))
                    st_d = nand_seq_pkg::S_STAT_CHK;
            end
            nand_seq_pkg::S_STAT_CHK:
            begin
                rs_d.ready = stat_q[`ST_RDY_BIT];
                rs_d.array_ready = stat_q[`ST_ARRAY_READY_FLAG_BIT];
                // error flags count only once the matching ready holds
                if (stat_q[`ST_RDY_BIT])
                    rs_d.prior_cache_error = stat_q[`ST_PRIOR_CACHE_ERROR_FLAG_BIT];
                if (stat_q[`ST_RDY_BIT] && stat_q[`ST_ARRAY_READY_FLAG_BIT])
                    rs_d.op_error = stat_q[`ST_FAIL_BIT];
                st_d = nand_seq_pkg::S_IDLE;
                busy_d = 1'b0;
            end
            default:
                st_d = nand_seq_pkg::S_IDLE;
        endcase
        case (reg_addr)
            `REG_CTRL:    rdata_d = {31'h0, busy_q};
            `REG_ADDR_LO: rdata_d = addr_q[31:0];
            `REG_ADDR_HI: rdata_d = {24'h0, addr_q[39:32]};
            `REG_STATUS:  rdata_d = {24'h0, stat_q};
            `REG_RESULT:  rdata_d = {26'h0, rs_q};
            `REG_DIE:     rdata_d = {29'h0, die_q};
            default:      rdata_d = 32'h0;
        endcase
        if (!reg_rd)
            rdata_d = 32'h0;
    end

    always_ff @(posedge ref_clk)
    begin
        if (srst)
        begin
            st_q <= nand_seq_pkg::S_IDLE;
            bo_q <= '{dq: 8'h00, cle: 1'b0, ale: 1'b0, we_n: 1'b1, re_n: 1'b1, dq_oe: 1'b0};
            rs_q <= '{op_error: 1'b0, prior_cache_error: 1'b0, array_ready: 1'b1,
                      ready: 1'b1, move_open: 1'b0, order_error: 1'b0};
            op_q <= 3'h0;
            addr_q <= 40'h0;
            data_q <= 8'h00;
            data_full_q <= 1'b0;
            data_last_q <= 1'b0;
            busy_q <= 1'b0;
            cnt_q <= 3'h0;
            ph_q <= 3'h0;
            die_q <= 3'h0;
            stat_q <= 8'h00;
            next_page_q <= 6'h0;
            first_q <= 1'b1;
            reg_rdata <= 32'h0;
            data_ready <= 1'b1;
        end
        else
        begin
            st_q <= st_d;
            bo_q <= bo_d;
            rs_q <= rs_d;
            op_q <= op_d;
            addr_q <= addr_d;
            data_q <= data_d;
            data_full_q <= data_full_d;
            data_last_q <= data_last_d;
            busy_q <= busy_d;
            cnt_q <= cnt_d;
            ph_q <= ph_d;
            die_q <= die_d;
            stat_q <= stat_d;
            next_page_q <= next_page_d;
            first_q <= first_d;
            reg_rdata <= rdata_d;
            data_ready <= !data_full_d;
        end
    end

    assign dq_out = bo_q.dq;
    assign dq_oe  = bo_q.dq_oe;
    assign cle    = bo_q.cle;
    assign ale    = bo_q.ale;
    assign we_n   = bo_q.we_n;
    assign re_n   = bo_q.re_n;
    assign ce_n   = 1'b0;

    a_erase_needs_ready: assert property (@(posedge ref_clk) disable iff (srst)
        (st_q == nand_seq_pkg::S_IDLE && st_d == nand_seq_pkg::S_CMD && op_d == `OP_ERASE)
        |-> (rs_q.ready && rs_q.array_ready))
        else $error("erase started while die not fully ready");
    a_busy_status_only: assert property (@(posedge ref_clk) disable iff (srst)
        (st_q == nand_seq_pkg::S_IDLE && st_d == nand_seq_pkg::S_CMD && !rs_q.ready)
        |-> op_d == `OP_RESET)
        else $error("non-reset command issued while die fully busy");
    a_move_window: assert property (@(posedge ref_clk) disable iff (srst)
        (st_q == nand_seq_pkg::S_IDLE && st_d == nand_seq_pkg::S_CMD && rs_q.move_open)
        |-> (op_d inside {`OP_MOVE_PROG, `OP_COL_CHANGE, `OP_RESET}))
        else $error("illegal command inside move window");
    a_status_enhanced: assert property (@(posedge ref_clk) disable iff (srst)
        (st_q != nand_seq_pkg::S_STAT_CMD && st_d == nand_seq_pkg::S_STAT_CMD)
        |=> bo_q.dq == `CMD_STATUS_ENH)
        else $error("status poll not using status-enhanced");
    a_cache_confirm: assert property (@(posedge ref_clk) disable iff (srst)
        (st_q == nand_seq_pkg::S_DATA && st_d == nand_seq_pkg::S_CONF
        && op_q == `OP_CACHE_PROG) |=> bo_q.dq == `CMD_CACHE_CONFIRM)
        else $error("cached program not confirmed with 15h");
    a_erase_rows: assert property (@(posedge ref_clk) disable iff (srst)
        (st_q == nand_seq_pkg::S_CMD && st_d == nand_seq_pkg::S_ADDR && op_q == `OP_ERASE)
        |=> cnt_q == 3'h2)
        else $error("erase did not send three row cycles");
    a_move_prog_cmd: assert property (@(posedge ref_clk) disable iff (srst)
        (st_q == nand_seq_pkg::S_IDLE && st_d == nand_seq_pkg::S_CMD
        && op_d == `OP_MOVE_PROG) |=> bo_q.dq == `CMD_COL_CHANGE)
        else $error("move-program not opened with 85h");
    a_move_read_conf: assert property (@(posedge ref_clk) disable iff (srst)
        (st_q == nand_seq_pkg::S_ADDR && st_d == nand_seq_pkg::S_CONF
        && op_q == `OP_MOVE_READ) |=> bo_q.dq == `CMD_MOVE_CONFIRM)
        else $error("move-read not confirmed with 35h");
endmodule

// file: testbench/nand_die_model.sv
// behavioural nand die answering the controller's bus cycles
`timescale 1ns/1ps
module nand_die_model #(
    parameter int CBSY_CYC = 40,
    parameter int PROG_CYC = 80,
    parameter int BERS_CYC = 120
) (
    input  wire logic       ref_clk,
    input  wire logic [7:0] dq_out,
    output logic      [7:0] dq_in,
    input  wire logic       cle,
    input  wire logic       ale,
    input  wire logic       we_n,
    input  wire logic       re_n,
    output logic            ready_busy_n,
    input  wire logic       fail_next
);
    logic [7:0] cache [0:63];
    logic [7:0] col = 8'h00;
    logic [7:0] last_dq = 8'h00;
    logic       we_q = 1'b1;
    logic       fail = 1'b0;
    logic       prior_cache_error_flag = 1'b0;
    logic       move_open = 1'b0;
    logic       bad_cmd = 1'b0;
    int         n_addr = 0;
    int         conf_addr = 0;
    int         busy_cnt = 0;
    int         arr_cnt = 0;
    wire  [7:0] status = {1'b0, busy_cnt == 0, arr_cnt == 0, 3'h0, prior_cache_error_flag, fail};
    // released bus toggles so a stale value never reads as good
    assign dq_in = re_n ? ~last_dq : status;
    assign ready_busy_n = (busy_cnt == 0);
    always @(posedge ref_clk)
    begin
        last_dq <= dq_in;
        we_q <= we_n;
        busy_cnt <= (busy_cnt > 0) ? busy_cnt - 1 : 0;
        arr_cnt <= (arr_cnt > 0) ? arr_cnt - 1 : 0;
        if (we_n && !we_q && cle)
        begin
            n_addr <= 0;
            if (busy_cnt != 0 && !(dq_out inside {8'h70, 8'h78, 8'hff}))
                bad_cmd <= 1'b1;
            if (move_open && !(dq_out inside {8'h70, 8'h78, 8'h05, 8'h06, 8'he0, 8'h85,
                8'h10, 8'hff}))
                bad_cmd <= 1'b1;
            if (dq_out inside {8'h10, 8'h15, 8'hd0, 8'h35})
                conf_addr <= n_addr;
            case (dq_out)
                8'h80: foreach (cache[i]) cache[i] <= 8'h00;
                8'h15:
                begin
                    busy_cnt <= CBSY_CYC;
                    arr_cnt <= arr_cnt + CBSY_CYC + PROG_CYC;
                    prior_cache_error_flag <= fail;
                    fail <= fail_next;
                end
                8'h10:
                begin
                    busy_cnt <= arr_cnt + PROG_CYC;
                    arr_cnt <= arr_cnt + PROG_CYC;
                    prior_cache_error_flag <= fail;
                    fail <= fail_next;
                    move_open <= 1'b0;
                end
                8'hd0:
                begin
                    if (arr_cnt != 0)
                        bad_cmd <= 1'b1;
                    busy_cnt <= BERS_CYC;
                    arr_cnt <= BERS_CYC;
                    fail <= fail_next;
                end
                8'h35:
                begin
                    busy_cnt <= CBSY_CYC;
                    move_open <= 1'b1;
                    foreach (cache[i]) cache[i] <= 8'(i) ^ 8'h5a;
                end
                8'hff:
                begin
                    busy_cnt <= 2;
                    move_open <= 1'b0;
                    foreach (cache[i]) cache[i] <= 8'hxx;
                end
                default: ;
            endcase
        end
        else if (we_n && !we_q && ale)
        begin
            if (n_addr == 0)
                col <= dq_out;
            n_addr <= n_addr + 1;
        end
        else if (we_n && !we_q)
        begin
            cache[col[5:0]] <= dq_out;
            col <= col + 8'h01;
        end
    end
endmodule

// file: testbench/tb_nand_seq_ctrl.sv
// self-checking bench for the nand program, erase and move controller
`timescale 1ns/1ps
`include "nand_seq_map.svh"
module tb_nand_seq_ctrl;
    logic        ref_clk = 1'b0;
    logic        srst = 1'b1;
    logic [3:0]  reg_addr = 4'h0;
    logic [31:0] reg_wdata = 32'h0;
    logic        reg_wr = 1'b0;
    logic        reg_rd = 1'b0;
    logic        fail_next = 1'b0;
    logic [31:0] reg_rdata, r;
    logic [7:0]  dq_out, dq_in;
    logic        data_ready, dq_oe, cle, ale, ce_n, we_n, re_n, ready_busy_n;
    int          err_count = 0;
    int          checked = 0;
    int          cycles = 0;
    nand_seq_ctrl i_dut (.ref_clk(ref_clk), .srst(srst), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .data_ready(data_ready), .dq_out(dq_out), .dq_oe(dq_oe), .dq_in(dq_in), .cle(cle),
        .ale(ale), .ce_n(ce_n), .we_n(we_n), .re_n(re_n), .ready_busy_n(ready_busy_n));
    nand_die_model i_die (.ref_clk(ref_clk), .dq_out(dq_out), .dq_in(dq_in), .cle(cle),
        .ale(ale), .we_n(we_n), .re_n(re_n), .ready_busy_n(ready_busy_n),
        .fail_next(fail_next));
    initial
        forever #10 ref_clk = ~ref_clk;
    task automatic summarize();
        $display("checks %0d mismatches %0d", checked, err_count);
        if (err_count == 0 && checked > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    // ceiling well above the roughly 1300 cycles the tests need
    always @(posedge ref_clk)
    begin
        cycles++;
        if (cycles == 40000)
        begin
            err_count++;
            summarize();
        end
    end
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp)
        begin
            err_count++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    // one gap cycle after each strobe keeps every signal to one assignment per step
    task automatic wr(input logic [3:0] a, input logic [31:0] d);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge ref_clk);
        reg_wr <= 1'b0;
        @(posedge ref_clk);
    endtask
    task automatic rd(input logic [3:0] a, output logic [31:0] d);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge ref_clk);
        reg_rd <= 1'b0;
        #1 d = reg_rdata;
        @(posedge ref_clk);
    endtask
    task automatic run_op(input logic [2:0] op, input logic [7:0] col, input logic [7:0] row,
                          input logic [7:0] b0, input int nb);
        logic [31:0] c;
        wr(`REG_ADDR_LO, {8'h00, row, 8'h00, col});
        wr(`REG_ADDR_HI, 32'h0);
        wr(`REG_CTRL, {29'h0, op});
        rd(`REG_CTRL, c);
        for (int i = 0; i < nb && c[0] === 1'b1; i++)
        begin
            for (int k = 0; k < 200 && data_ready !== 1'b1; k++)
                @(posedge ref_clk);
            wr(`REG_DATA, {23'h0, i == nb - 1, b0 + 8'(i)});
        end
        for (int k = 0; k < 400 && c[0] !== 1'b0; k++)
            rd(`REG_CTRL, c);
    endtask
    initial
    begin
        repeat (8) @(posedge ref_clk);
        srst <= 1'b0;
        @(posedge ref_clk);
        #1 check(32'(data_ready), 32'h1);
        @(posedge ref_clk);
        wr(`REG_DIE, 32'h0);
        run_op(`OP_ERASE, 8'h00, 8'h40, 8'h00, 0);
        check(i_die.conf_addr, 3);
        rd(`REG_RESULT, r);
        check(32'(r[5:2]), 32'h3);
        fail_next <= 1'b1;
        run_op(`OP_ERASE, 8'h00, 8'h80, 8'h00, 0);
        fail_next <= 1'b0;
        rd(`REG_RESULT, r);
        check(32'(r[5]), 32'h1);
        $display("test erase done");
        run_op(`OP_CACHE_PROG, 8'h02, 8'h00, 8'ha1, 2);
        check(i_die.conf_addr, 5);
        check(32'(i_die.cache[2]), 32'ha1);
        check(32'(i_die.cache[3]), 32'ha2);
        check(32'(i_die.cache[0]), 32'h00);
        rd(`REG_RESULT, r);
        check(32'(r[4:2]), 32'h5);
        run_op(`OP_PAGE_PROG, 8'h02, 8'h01, 8'hc3, 1);
        check(32'(i_die.cache[3]), 32'h00);
        rd(`REG_RESULT, r);
        check(32'(r[5:2]), 32'h3);
        $display("test cache program done");
        run_op(`OP_PAGE_PROG, 8'h00, 8'h00, 8'h11, 1);
        rd(`REG_RESULT, r);
        check(32'(r[0]), 32'h1);
        wr(`REG_RESULT, 32'h1);
        rd(`REG_RESULT, r);
        check(32'(r[0]), 32'h0);
        $display("test page order done");
        run_op(`OP_CACHE_PROG, 8'h00, 8'h02, 8'h21, 1);
        rd(`REG_RESULT, r);
        check(32'(r[4:2]), 32'h1);
        for (int k = 0; k < 40 && r[3] !== 1'b1; k++)
        begin
            wr(`REG_CTRL, 32'h8);
            repeat (20) @(posedge ref_clk);
            rd(`REG_RESULT, r);
        end
        check(32'(r[5:2]), 32'h3);
        $display("test status poll done");
        run_op(`OP_MOVE_READ, 8'h00, 8'h05, 8'h00, 0);
        run_op(`OP_RESET, 8'h00, 8'h00, 8'h00, 0);
        rd(`REG_RESULT, r);
        check(32'(r[1]), 32'h0);
        run_op(`OP_MOVE_READ, 8'h00, 8'h05, 8'h00, 0);
        rd(`REG_RESULT, r);
        check(32'(r[1]), 32'h1);
        run_op(`OP_COL_CHANGE, 8'h03, 8'h00, 8'h66, 1);
        check(32'(i_die.cache[3]), 32'h66);
        run_op(`OP_MOVE_PROG, 8'h01, 8'h0a, 8'h77, 1);
        check(32'(i_die.cache[1]), 32'h77);
        check(32'(i_die.cache[2]), 32'h58);
        rd(`REG_RESULT, r);
        check(32'(r[1]), 32'h0);
        check(32'(i_die.bad_cmd), 32'h0);
        $display("test internal move done");
        summarize();
    end
endmodule
